// ### shared/irq_mask_pkg.sv
package irq_mask_pkg;

   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 32;
   localparam int ECNT_W   = 13;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] STATUS0_ADDR = 12'h402;
   localparam logic [ADDR_W-1:0] STATUS1_ADDR = 12'h403;
   localparam logic [ADDR_W-1:0] MASK0_ADDR   = 12'h405;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_MASK_HIGH_ADDR   = 12'h406;
   localparam logic [ADDR_W-1:0] RESULT_ADDR  = 12'h45E;
   localparam logic [ADDR_W-1:0] FORCE_ADDR   = 12'h45F;

   localparam logic [DATA_W-1:0] RST_WORD   = 32'h0000_0000;
   localparam logic [DATA_W-1:0] MASK0_WR   = 32'h0000_0003;
   localparam logic [DATA_W-1:0] IRQ_ENABLE_MASK_HIGH_WR   = 32'hFC04_FFC0;
   localparam logic [DATA_W-1:0] NMI_BITS   = 32'h3000_0000;
   localparam logic [DATA_W-1:0] HOLD_BITS  = 32'hB000_0000;

   // ----------------------------------------------------------------
   // bit positions
   // ----------------------------------------------------------------
   localparam int B_ENERGY     = 0;
   localparam int B_SIGN_FLIP  = 1;
   localparam int B_FAULT3     = 31;
   localparam int B_FAULT2     = 30;
   localparam int B_FAULT1     = 29;
   localparam int B_FAULT0     = 28;
   localparam int B_CRC_DONE   = 27;
   localparam int B_CFG_CHECK_CHANGED    = 26;
   localparam int B_ORDER      = 18;
   localparam int B_CUR_A      = 13;
   localparam int B_VSUM       = 12;
   localparam int B_VOLT_A     = 9;
   localparam int B_TMO_A      = 6;
   localparam int B_FORCE      = 0;
   localparam int NPH          = 3;

   // one-cycle event pulses; phase vectors are [2]=C [1]=B [0]=A
   typedef struct packed {
      logic           fault_three;
      logic           fault_two;
      logic           fault_one;
      logic           fault_zero;
      logic           phase_order_fault;
      logic [NPH-1:0] cur_crossing;
      logic           volt_sum_crossing;
      logic [NPH-1:0] volt_crossing;
      logic [NPH-1:0] volt_crossing_timeout;
   } event_in_type;

   typedef struct packed {
      logic [ECNT_W-1:0] energy_interval_count;
      logic              energy_timer_select;
      logic              sample_strobe;
      logic              line_cycle_strobe;
   } energy_in_type;

   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] value;
   } check_in_type;

endpackage

// ### hdl/sticky_flags.sv
`timescale 1ns/1ps
// set wins over a write-one clear; flush (soft reset) wins over both
module sticky_flags #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   input  wire logic             flush_i,
   input  wire logic [WIDTH-1:0] set_i,
   input  wire logic [WIDTH-1:0] clr_i,
   output logic      [WIDTH-1:0] flags_o
);

   logic [WIDTH-1:0] flags_d;

   always_comb begin
      flags_d = flags_o;
      if (ce_i) begin
         if (flush_i) begin
            flags_d = '0;
         end else begin
            flags_d = set_i | (flags_o & ~clr_i);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_o <= '0;
      end else begin
         flags_o <= flags_d;
      end
   end

endmodule

// ### hdl/irq_mask_core.sv
`timescale 1ns/1ps
module irq_mask_core #(
   parameter int CNT_W = irq_mask_pkg::ECNT_W
) (
   input  wire logic                           clk_i,
   input  wire logic                           rst_n_i,
   input  wire logic                           ce_i,
   input  wire logic                           sw_reset_i,
   input  wire logic [irq_mask_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic                           reg_wr_i,
   input  wire logic                           reg_rd_i,
   input  wire logic [irq_mask_pkg::DATA_W-1:0] reg_wdata_i,
   output logic      [irq_mask_pkg::DATA_W-1:0] reg_rdata_o,
   input  wire logic                           pa_sign_neg_i,
   input  wire irq_mask_pkg::energy_in_type    energy_i,
   input  wire irq_mask_pkg::event_in_type     event_i,
   input  wire irq_mask_pkg::check_in_type     check_i,
   output logic                                crc_force_o,
   output logic                                irq_n_o
);

   localparam int DW = irq_mask_pkg::DATA_W;

   function automatic logic hit(input logic [irq_mask_pkg::ADDR_W-1:0] a,
                                input logic [irq_mask_pkg::ADDR_W-1:0] b);
      return a == b;
   endfunction

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [DW-1:0]    mask0_q, mask0_d;
   logic [DW-1:0]    irq_enable_mask_high_q, irq_enable_mask_high_d;
   logic [DW-1:0]    result_q, result_d;
   logic             result_ok_q, result_ok_d;
   logic             force_pend_q, force_pend_d;
   logic             crc_force_d;
   logic [DW-1:0]    rdata_d;
   logic             irq_n_d;
   logic             sign_q, sign_d;
   logic             sign_ok_q, sign_ok_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [DW-1:0]    st0_q, st1_q;
   logic [DW-1:0]    set0, set1, clr0, clr1;
   logic             e_strobe, e_fire, pending;
   logic [CNT_W-1:0] e_last;

   // ----------------------------------------------------------------
   // event sources
   // ----------------------------------------------------------------
   always_comb begin
      // an interval of zero is treated as one
      e_strobe = energy_i.energy_timer_select ? energy_i.line_cycle_strobe
                                              : energy_i.sample_strobe;
      e_last   = (energy_i.energy_interval_count == '0) ? '0
                 : CNT_W'(energy_i.energy_interval_count) - CNT_W'(1);
      e_fire   = e_strobe && (cnt_q >= e_last);
      cnt_d    = cnt_q;
      if (e_strobe) begin
         cnt_d = e_fire ? '0 : cnt_q + CNT_W'(1);
      end
      // the first sample after reset only seeds the sign history
      sign_d    = pa_sign_neg_i;
      sign_ok_d = 1'b1;
   end

   always_comb begin
      set0 = '0;
      set1 = '0;
      set0[irq_mask_pkg::B_ENERGY]    = e_fire;
      set0[irq_mask_pkg::B_SIGN_FLIP] = sign_ok_q &&
                                        (pa_sign_neg_i != sign_q);
      set1[irq_mask_pkg::B_FAULT3] = event_i.fault_three;
      set1[irq_mask_pkg::B_FAULT2] = event_i.fault_two;
      set1[irq_mask_pkg::B_FAULT1] = event_i.fault_one;
      set1[irq_mask_pkg::B_FAULT0] = event_i.fault_zero;
      set1[irq_mask_pkg::B_CRC_DONE] = check_i.valid && force_pend_q;
      set1[irq_mask_pkg::B_CFG_CHECK_CHANGED]  = check_i.valid && result_ok_q &&
                                       (check_i.value != result_q);
      set1[irq_mask_pkg::B_ORDER] = event_i.phase_order_fault;
      for (int p = 0; p < irq_mask_pkg::NPH; p++) begin
         set1[irq_mask_pkg::B_CUR_A + p]  = event_i.cur_crossing[p];
         set1[irq_mask_pkg::B_VOLT_A + p] = event_i.volt_crossing[p];
         set1[irq_mask_pkg::B_TMO_A + p]  =
            event_i.volt_crossing_timeout[p];
      end
      set1[irq_mask_pkg::B_VSUM] = event_i.volt_sum_crossing;
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   always_comb begin
      clr0 = '0;
      clr1 = '0;
      if (reg_wr_i && hit(reg_addr_i, irq_mask_pkg::STATUS0_ADDR)) begin
         clr0 = reg_wdata_i & irq_mask_pkg::MASK0_WR;
      end
      // latched faults ignore the write-one clear
      if (reg_wr_i && hit(reg_addr_i, irq_mask_pkg::STATUS1_ADDR)) begin
         clr1 = reg_wdata_i & irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_WR &
                ~irq_mask_pkg::HOLD_BITS;
      end
   end

   always_comb begin
      mask0_d      = mask0_q;
      irq_enable_mask_high_d      = irq_enable_mask_high_q;
      result_d     = result_q;
      result_ok_d  = result_ok_q;
      force_pend_d = force_pend_q;
      crc_force_d  = 1'b0;
      if (reg_wr_i && hit(reg_addr_i, irq_mask_pkg::MASK0_ADDR)) begin
         mask0_d = reg_wdata_i & irq_mask_pkg::MASK0_WR;
      end
      if (reg_wr_i && hit(reg_addr_i, irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR)) begin
         irq_enable_mask_high_d = reg_wdata_i & irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_WR;
      end
      if (check_i.valid) begin
         result_d     = check_i.value;
         result_ok_d  = 1'b1;
         force_pend_d = 1'b0;
      end
      // a force during a running computation waits for the next result
      if (reg_wr_i && hit(reg_addr_i, irq_mask_pkg::FORCE_ADDR) &&
          reg_wdata_i[irq_mask_pkg::B_FORCE]) begin
         force_pend_d = 1'b1;
         crc_force_d  = 1'b1;
      end
   end

   always_comb begin
      rdata_d = irq_mask_pkg::RST_WORD;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            irq_mask_pkg::STATUS0_ADDR: rdata_d = st0_q;
            irq_mask_pkg::STATUS1_ADDR: rdata_d = st1_q;
            irq_mask_pkg::MASK0_ADDR:   rdata_d = mask0_q;
            irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR:   rdata_d = irq_enable_mask_high_q;
            irq_mask_pkg::RESULT_ADDR:  rdata_d = result_q;
            default:                    rdata_d = irq_mask_pkg::RST_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupt combine
   // ----------------------------------------------------------------
   always_comb begin
      pending = |(st0_q & mask0_q) |
                |(st1_q & irq_enable_mask_high_q & ~irq_mask_pkg::NMI_BITS) |
                |(st1_q & irq_mask_pkg::NMI_BITS);
      irq_n_d = ~pending;
   end

   sticky_flags #(
      .WIDTH (2*DW)
   ) u_flags (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .ce_i    (ce_i),
      .flush_i (sw_reset_i),
      .set_i   ({set1, set0}),
      .clr_i   ({clr1, clr0}),
      .flags_o ({st1_q, st0_q})
   );

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask0_q      <= irq_mask_pkg::RST_WORD;
         irq_enable_mask_high_q      <= irq_mask_pkg::RST_WORD;
         result_q     <= irq_mask_pkg::RST_WORD;
         result_ok_q  <= 1'b0;
         force_pend_q <= 1'b0;
         crc_force_o  <= 1'b0;
         reg_rdata_o  <= irq_mask_pkg::RST_WORD;
         irq_n_o      <= 1'b1;
         sign_q       <= 1'b0;
         sign_ok_q    <= 1'b0;
         cnt_q        <= '0;
      end else if (ce_i) begin
         if (sw_reset_i) begin
            mask0_q      <= irq_mask_pkg::RST_WORD;
            irq_enable_mask_high_q      <= irq_mask_pkg::RST_WORD;
            result_q     <= irq_mask_pkg::RST_WORD;
            result_ok_q  <= 1'b0;
            force_pend_q <= 1'b0;
            crc_force_o  <= 1'b0;
            reg_rdata_o  <= irq_mask_pkg::RST_WORD;
            irq_n_o      <= 1'b1;
            sign_q       <= 1'b0;
            sign_ok_q    <= 1'b0;
            cnt_q        <= '0;
         end else begin
            mask0_q      <= mask0_d;
            irq_enable_mask_high_q      <= irq_enable_mask_high_d;
            result_q     <= result_d;
            result_ok_q  <= result_ok_d;
            force_pend_q <= force_pend_d;
            crc_force_o  <= crc_force_d;
            reg_rdata_o  <= rdata_d;
            irq_n_o      <= irq_n_d;
            sign_q       <= sign_d;
            sign_ok_q    <= sign_ok_d;
            cnt_q        <= cnt_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_force_write;
      ce_i && !sw_reset_i && reg_wr_i &&
      hit(reg_addr_i, irq_mask_pkg::FORCE_ADDR) &&
      reg_wdata_i[irq_mask_pkg::B_FORCE];
   endsequence

   sequence s_forced_done;
      ce_i && !sw_reset_i && force_pend_q && check_i.valid;
   endsequence

   AST_FORCE_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_force_write |=> crc_force_o && force_pend_q)
      else $error("forced update did not start");

   AST_CRC_DONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_forced_done |=> st1_q[irq_mask_pkg::B_CRC_DONE])
      else $error("check done flag missing");

   AST_CFG_CHECK_CHANGED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !sw_reset_i && check_i.valid && result_ok_q &&
       check_i.value != result_q)
      |=> st1_q[irq_mask_pkg::B_CFG_CHECK_CHANGED] &&
          result_q == $past(check_i.value))
      else $error("check change not flagged or result not held");

   AST_FAULT3_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (st1_q[irq_mask_pkg::B_FAULT3] && !(ce_i && sw_reset_i))
      |=> st1_q[irq_mask_pkg::B_FAULT3])
      else $error("fault three cleared without reset");

   AST_NMI_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !sw_reset_i && |(st1_q & irq_mask_pkg::NMI_BITS))
      |=> !irq_n_o)
      else $error("unmaskable fault did not interrupt");

   AST_FAULT2_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !sw_reset_i && st1_q[irq_mask_pkg::B_FAULT2] &&
       irq_enable_mask_high_q[irq_mask_pkg::B_FAULT2]) |=> !irq_n_o)
      else $error("enabled fault two did not interrupt");

   AST_IRQ_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !pending) |=> irq_n_o)
      else $error("interrupt without an enabled cause");

   AST_MASK_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ((irq_enable_mask_high_q & ~irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_WR) == '0) &&
      ((mask0_q & ~irq_mask_pkg::MASK0_WR) == '0))
      else $error("reserved enable bit set");

   AST_SIGN_FLIP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !sw_reset_i && sign_ok_q && pa_sign_neg_i != sign_q)
      |=> st0_q[irq_mask_pkg::B_SIGN_FLIP])
      else $error("sign flip not flagged");

   AST_ENERGY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !sw_reset_i && e_strobe && cnt_q >= e_last)
      |=> st0_q[irq_mask_pkg::B_ENERGY] && cnt_q == '0)
      else $error("energy interval end not flagged");

   AST_VOLT_A: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !sw_reset_i && event_i.volt_crossing[0])
      |=> st1_q[irq_mask_pkg::B_VOLT_A])
      else $error("phase A voltage crossing lost");

endmodule

// ### dv/host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host processor on the register port
// ------------------------------------------------------------
// idle address and data lines show the inverse of the last value
module host_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic        force_i,
   output logic      [11:0] addr_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic      [31:0] wdata_o,
   output logic             sw_reset_o
);
   int force_seen = 0;
   initial begin
      addr_o     = 12'h000;
      wr_o       = 1'b0;
      rd_o       = 1'b0;
      wdata_o    = 32'h0000_0000;
      sw_reset_o = 1'b0;
   end
   always @(posedge clk_i) begin
      if (force_i === 1'b1) force_seen++;
   end
   task automatic write(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic read(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      @(negedge clk_i);
      d = rdata_i;
   endtask
   // sticky faults only leave through a reset from this side
   task automatic soft_reset();
      @(posedge clk_i);
      sw_reset_o <= 1'b1;
      @(posedge clk_i);
      sw_reset_o <= 1'b0;
   endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic                        clk     = 1'b0;
   logic                        rst_n   = 1'b0;
   logic                        ce      = 1'b1;
   logic                        pa_sign = 1'b0;
   irq_mask_pkg::energy_in_type en      = '0;
   irq_mask_pkg::event_in_type  ev      = '0;
   irq_mask_pkg::check_in_type  ck      = '0;
   logic [11:0]                 addr;
   logic                        wr;
   logic                        rd;
   logic                        swr;
   logic                        force_p;
   logic                        irq_n;
   logic [31:0]                 wdata;
   logic [31:0]                 rdata;
   logic [31:0]                 m;
   logic [31:0]                 v;
   int                          num_errors      = 0;
   int                          samples_checked = 0;
   int                          cycles          = 0;
   int                          seed            = 32'h4a292c83;
   int                          b;
   int                          c;
   int                          f0;
   always #5 clk = ~clk;
   host_model host (
      .clk_i      (clk),
      .rdata_i    (rdata),
      .force_i    (force_p),
      .addr_o     (addr),
      .wr_o       (wr),
      .rd_o       (rd),
      .wdata_o    (wdata),
      .sw_reset_o (swr)
   );
   irq_mask_core dut (
      .clk_i         (clk),
      .rst_n_i       (rst_n),
      .ce_i          (ce),
      .sw_reset_i    (swr),
      .reg_addr_i    (addr),
      .reg_wr_i      (wr),
      .reg_rd_i      (rd),
      .reg_wdata_i   (wdata),
      .reg_rdata_o   (rdata),
      .pa_sign_neg_i (pa_sign),
      .energy_i      (en),
      .event_i       (ev),
      .check_i       (ck),
      .crc_force_o   (force_p),
      .irq_n_o       (irq_n)
   );
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // struct bit index of an event to its status bit
   function automatic int sbit(input int i);
      return i < 10 ? 6 + i : (i == 10 ? 18 : 17 + i);
   endfunction
   function automatic logic irq_exp(input logic [31:0] mk, input int k);
      return ~(mk[k] | irq_mask_pkg::NMI_BITS[k]);
   endfunction
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] got;
      host.read(a, got);
      chk_word(got, exp);
   endtask
   // irq is registered one edge after the cause is taken
   task automatic settle();
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic fire(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= '0;
      settle();
   endtask
   task automatic strobe(input logic line);
      @(posedge clk);
      en.sample_strobe     <= ~line;
      en.line_cycle_strobe <= line;
      @(posedge clk);
      en.sample_strobe     <= 1'b0;
      en.line_cycle_strobe <= 1'b0;
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      chk_bit(irq_n, 1'b1);
      rd_chk(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, 32'h0000_0000);
      host.write(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, 32'hFFFF_FFFF);
      rd_chk(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_WR);
      rd_chk(12'h400, 32'h0000_0000);
      $display("test reset_and_reserved done");
      for (int i = 0; i < 15; i++) begin
         b = sbit(i);
         m = $random(seed) & irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_WR;
         m[b] = i[0];
         host.write(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, m);
         fire(i);
         chk_bit(irq_n, irq_exp(m, b));
         rd_chk(irq_mask_pkg::STATUS1_ADDR, 32'h1 << b);
         host.write(irq_mask_pkg::STATUS1_ADDR, 32'h1 << b);
         if (irq_mask_pkg::HOLD_BITS[b]) begin
            rd_chk(irq_mask_pkg::STATUS1_ADDR, 32'h1 << b);
            host.soft_reset();
            rd_chk(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, 32'h0000_0000);
         end
         rd_chk(irq_mask_pkg::STATUS1_ADDR, 32'h0000_0000);
         chk_bit(irq_n, 1'b1);
      end
      $display("test events done");
      for (int k = 1; k >= 0; k--) begin
         host.write(irq_mask_pkg::MASK0_ADDR, {30'h0, k[0], 1'b0});
         @(posedge clk);
         pa_sign <= ~pa_sign;
         @(posedge clk);
         settle();
         chk_bit(irq_n, ~k[0]);
         rd_chk(irq_mask_pkg::STATUS0_ADDR, 32'h0000_0002);
         host.write(irq_mask_pkg::STATUS0_ADDR, 32'h0000_0002);
      end
      $display("test sign_flip done");
      host.write(irq_mask_pkg::MASK0_ADDR, 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         c = (k == 0) ? 1 : k;
         en.energy_interval_count <= 13'(k);
         en.energy_timer_select   <= k[0];
         repeat (c) strobe(~k[0]);
         repeat (c - 1) strobe(k[0]);
         rd_chk(irq_mask_pkg::STATUS0_ADDR, 32'h0000_0000);
         strobe(k[0]);
         settle();
         chk_bit(irq_n, 1'b0);
         rd_chk(irq_mask_pkg::STATUS0_ADDR, 32'h0000_0001);
         host.write(irq_mask_pkg::STATUS0_ADDR, 32'h0000_0001);
      end
      $display("test energy done");
      host.write(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, 32'h0C00_0000);
      f0 = host.force_seen;
      host.write(irq_mask_pkg::FORCE_ADDR, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk_word(32'(host.force_seen - f0), 32'h0000_0001);
      v = $random(seed);
      for (int k = 0; k < 3; k++) begin
         if (k == 1) v = ~v;
         @(posedge clk);
         ck <= '{1'b1, v};
         @(posedge clk);
         ck.valid <= 1'b0;
         settle();
         chk_bit(irq_n, k == 2);
         m = (k == 0) ? 32'h0800_0000 : (k == 1) ? 32'h0400_0000 : 32'h0;
         rd_chk(irq_mask_pkg::STATUS1_ADDR, m);
         rd_chk(irq_mask_pkg::RESULT_ADDR, v);
         host.write(irq_mask_pkg::STATUS1_ADDR, 32'h0C00_0000);
      end
      $display("test config_check done");
      // a low enable drops events and writes; only reset frees held faults
      fire(12);
      @(posedge clk);
      ce <= 1'b0;
      fire(3);
      host.write(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, 32'h0000_0000);
      chk_bit(irq_n, 1'b0);
      @(posedge clk);
      ce <= 1'b1;
      rd_chk(irq_mask_pkg::STATUS1_ADDR, 32'h2000_0000);
      rd_chk(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, 32'h0C00_0000);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk_bit(irq_n, 1'b1);
      rd_chk(irq_mask_pkg::STATUS1_ADDR, 32'h0000_0000);
      rd_chk(irq_mask_pkg::IRQ_ENABLE_MASK_HIGH_ADDR, 32'h0000_0000);
      $display("test freeze_and_reset done");
      print_verdict();
   end
endmodule
